/* design/adc_channel_config_regs.sv */
// channel 1/2 ADC config register bank behind an AXI4-Lite slave
//
// What this block does
// R1 - fine gain code 0..15 is -0.8..+0.7 dB
// R2 - fine gain register at 0x53 resets 0x80
// R3 - software writes zero to fine gain bits 3:0
// R4 - phase delay bits 7:2, 0..63 modulator cycles
// R5 - bits 1:0 pick both, analog, digital paths
// R6 - phase register at 0x54 resets to 0x00
// R7 - channel 2 bits 7:6 select input source
// R8 - channel 2 bits 5:4 select input impedance
// R9 - channel 2 bits 3:2 select common-mode tolerance
// R10 - high full scale only rail-to-rail, audio band
// R11 - wide band only with 40 k impedance
// R12 - channel 2 register at 0x55 resets 0x00
// R13 - fields hold writes; reserved bits read zero
`default_nettype none
`timescale 1ns/1ps
module adc_channel_config_regs (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  // axi4-lite write address
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [adc_cfg_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                      s_axi_awprot,
  // axi4-lite write data
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  input  wire logic [adc_cfg_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  // axi4-lite write response
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  output logic [1:0]                           s_axi_bresp,
  // axi4-lite read address
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  input  wire logic [adc_cfg_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                      s_axi_arprot,
  // axi4-lite read data
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic [adc_cfg_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  // configuration towards the analog and filter paths
  output adc_cfg_pkg::ch1_cfg_t                ch1_cfg,
  output adc_cfg_pkg::ch2_cfg_t                ch2_cfg,
  output adc_cfg_pkg::cfg_decoded_t            cfg_decoded
);
  import adc_cfg_pkg::*;

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  logic              aw_held_q;  // write address captured
  logic [ADDR_W-1:0] awaddr_q;   // captured write address
  logic              w_held_q;   // write data captured
  logic [7:0]        wbyte_q;    // captured low byte
  logic              wlane_q;    // low byte lane enabled
  logic              bvalid_q;   // response pending
  logic [1:0]        bresp_q;    // response code
  logic              aw_fire;    // address handshake
  logic              w_fire;     // data handshake
  logic              wr_fire;    // both halves present, commit now
  logic [NREG-1:0]   wr_hit;     // write address decode
  logic [NREG-1:0]   wr_en;      // per-register write strobe
  logic              wr_mapped;  // write lands on something
  logic [NREG-1:0][7:0] reg_q;   // register contents

  // no new capture while a response waits: one write in flight
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
  assign wr_mapped     = (|wr_hit) || addr_hit(awaddr_q, CFG_STATUS_IDX);
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // address half, either order with data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (aw_fire) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // data half; only the low byte lane carries register bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held_q <= 1'b0;
      wbyte_q  <= 8'h00;
      wlane_q  <= 1'b0;
    end else if (w_fire) begin
      w_held_q <= 1'b1;
      wbyte_q  <= s_axi_wdata[7:0];
      wlane_q  <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // response; status register takes writes silently
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  // read-only reserved bits are masked off inside each register
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    assign wr_hit[g] = addr_hit(awaddr_q, REG_IDX[g]);
    assign wr_en[g]  = wr_fire && wlane_q && wr_hit[g];   // [R13]
    cfg_reg8 #(
      .RST   (REG_RST[g]),                                // [R2] [R6] [R12]
      .WMASK (REG_WMASK[g])                               // [R13]
    ) u_reg (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (wr_en[g]),
      .wr_data (wbyte_q),
      .q       (reg_q[g])
    );
  end

  // ---------------------------------------------------------------
  // field split
  // ---------------------------------------------------------------
  assign ch1_cfg.ch1_fine_gain_code     = reg_q[0][FGAIN_LSB +: 4]; // [R1]
  assign ch1_cfg.ch1_phase_delay_cycles = reg_q[1][PDLY_LSB +: 6];  // [R4]
  assign ch1_cfg.phase_path = phase_path_t'(reg_q[1][PSEL_LSB +: 2]);
  assign ch2_cfg.ch2_input_source =
    input_source_t'(reg_q[2][INSRC_LSB +: 2]);                     // [R7]
  assign ch2_cfg.ch2_input_impedance =
    impedance_t'(reg_q[2][IMP_LSB +: 2]);                          // [R8]
  assign ch2_cfg.ch2_common_mode_tolerance =
    cm_tol_t'(reg_q[2][CMTOL_LSB +: 2]);                           // [R9]
  assign ch2_cfg.ch2_fullscale_select = reg_q[2][FS_BIT];
  assign ch2_cfg.ch2_bandwidth_select = reg_q[2][BW_BIT];

  // decode is registered so the outputs come straight from flops
  cfg_field_decode u_decode (
    .clk       (clk),
    .reset_n   (reset_n),
    .ch1_cfg   (ch1_cfg),
    .ch2_cfg   (ch2_cfg),
    .decoded_q (cfg_decoded)
  );

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic              rvalid_q;   // read data pending
  logic [7:0]        rbyte_q;    // read data low byte
  logic [1:0]        rresp_q;    // read response code
  logic              ar_fire;    // read address handshake
  logic [NREG-1:0]   rd_hit;     // read address decode
  logic [NREG-1:0][7:0] rd_part; // selected register or zero
  logic              rd_sts_hit; // status register selected
  logic [7:0]        rd_byte;    // assembled read byte
  logic              rd_mapped;  // address lands on something

  assign s_axi_arready = !rvalid_q;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  for (genvar g = 0; g < NREG; g++) begin : g_rd
    assign rd_hit[g]  = addr_hit(s_axi_araddr, REG_IDX[g]);
    assign rd_part[g] = rd_hit[g] ? reg_q[g] : 8'h00;    // [R13]
  end
  assign rd_sts_hit = addr_hit(s_axi_araddr, CFG_STATUS_IDX);
  assign rd_byte    = rd_part[0] | rd_part[1] | rd_part[2] |
                      (rd_sts_hit ? {3'h0, cfg_decoded.status} : 8'h00);
  assign rd_mapped  = (|rd_hit) || rd_sts_hit;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = {24'h000000, rbyte_q};
  assign s_axi_rresp  = rresp_q;

  // read answer; unmapped reads give zero with an error code
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rbyte_q  <= 8'h00;
      rresp_q  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rbyte_q  <= rd_byte;
      rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [4:0] exp_tenths;  // expected gain from the current code
  assign exp_tenths = {1'b0, ch1_cfg.ch1_fine_gain_code} - 5'h08;

  property p_fgain_db;
    @(posedge clk) disable iff (!reset_n)
      1 |=> cfg_decoded.fine_gain_tenths_db == $past(exp_tenths);
  endproperty
  a_fgain_db: assert property (p_fgain_db) // [R1]
    else $error("fine gain decode wrong");

  property p_reset_defaults;
    @(posedge clk) disable iff (!reset_n)
      $rose(reset_n) |-> reg_q[0] == 8'h80 && reg_q[1] == 8'h00 &&
                         reg_q[2] == 8'h00;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) // [R2] [R6] [R12]
    else $error("register not at reset value");

  property p_fgain_write;
    @(posedge clk) disable iff (!reset_n)
      wr_en[0] |=> reg_q[0] == {$past(wbyte_q[7:4]), 4'h0};
  endproperty
  a_fgain_write: assert property (p_fgain_write) // [R13]
    else $error("fine gain write not stored or low bits not zero");

  property p_pcal_write;
    @(posedge clk) disable iff (!reset_n)
      wr_en[1] |=> ch1_cfg.ch1_phase_delay_cycles == $past(wbyte_q[7:2])
                   ##1 cfg_decoded.digital_delay_en ==
                       ($past(wbyte_q[1:0], 2) != 2'h1 &&
                        $past(wbyte_q[1:0], 2) != 2'h3);
  endproperty
  a_pcal_write: assert property (p_pcal_write) // [R4] [R5]
    else $error("phase delay write or path decode wrong");

  property p_path_analog;
    @(posedge clk) disable iff (!reset_n)
      1 |=> cfg_decoded.analog_delay_en ==
            ($past(reg_q[1][1:0]) == 2'h0 || $past(reg_q[1][1:0]) == 2'h1);
  endproperty
  a_path_analog: assert property (p_path_analog) // [R5]
    else $error("analog delay enable wrong");

  property p_input_write;
    @(posedge clk) disable iff (!reset_n)
      wr_en[2] |=> ch2_cfg.ch2_input_source == $past(wbyte_q[7:6]) &&
                   ch2_cfg.ch2_input_impedance == $past(wbyte_q[5:4]) &&
                   ch2_cfg.ch2_common_mode_tolerance == $past(wbyte_q[3:2]);
  endproperty
  a_input_write: assert property (p_input_write) // [R7] [R8] [R9]
    else $error("channel 2 fields not stored");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
      !wr_fire |=> $stable(reg_q);
  endproperty
  a_hold: assert property (p_hold) // [R13]
    else $error("register changed without a write");

  property p_read_back;
    @(posedge clk) disable iff (!reset_n)
      ar_fire && rd_hit[2] |=> s_axi_rvalid &&
        s_axi_rdata == {24'h000000, $past(reg_q[2])} &&
        s_axi_rresp == 2'h0;
  endproperty
  a_read_back: assert property (p_read_back) // [R13]
    else $error("read data differs from register");

  property p_write_resp;
    @(posedge clk) disable iff (!reset_n)
      aw_fire && w_fire |=> wr_fire ##1 s_axi_bvalid [*1];
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response not two cycles after handshakes");

  // flag must follow the misuse condition both ways, also during legal use
  property p_wb_flag;
    @(posedge clk) disable iff (!reset_n)
      1 |=> cfg_decoded.status[STS_BW_MISUSE] ==
            $past(ch2_cfg.ch2_bandwidth_select &&
                  ch2_cfg.ch2_input_impedance != IMP_40K);
  endproperty
  a_wb_flag: assert property (p_wb_flag) // [R11]
    else $error("wide band misuse flag wrong");

  c_fgain_write: cover property (@(posedge clk) disable iff (!reset_n)
    wr_en[0]);
  c_status_read: cover property (@(posedge clk) disable iff (!reset_n)
    ar_fire && rd_sts_hit);
  c_wideband_ok: cover property (@(posedge clk) disable iff (!reset_n)
    ch2_cfg.ch2_bandwidth_select && ch2_cfg.ch2_input_impedance == IMP_40K);
  c_bad_addr: cover property (@(posedge clk) disable iff (!reset_n)
    wr_fire && !wr_mapped);
endmodule : adc_channel_config_regs
`default_nettype wire

/* design/cfg_field_decode.sv */
// registered decode of config fields into steering and status bits
`default_nettype none
`timescale 1ns/1ps
module cfg_field_decode (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // raw fields
  input  wire adc_cfg_pkg::ch1_cfg_t     ch1_cfg,
  input  wire adc_cfg_pkg::ch2_cfg_t     ch2_cfg,
  // decoded, one cycle behind the fields
  output adc_cfg_pkg::cfg_decoded_t      decoded_q
);
  import adc_cfg_pkg::*;
  cfg_decoded_t decoded_d;  // next decoded value
  phase_path_t  path;       // selected phase path
  assign path = ch1_cfg.phase_path;
  // 0.1 dB per step, code 8 is 0 dB
  assign decoded_d.fine_gain_tenths_db =
    {1'b0, ch1_cfg.ch1_fine_gain_code} - FGAIN_ZERO_CODE;   // [R1]
  // reserved path code steers the delay nowhere
  assign decoded_d.analog_delay_en  =
    (path == PATH_BOTH) || (path == PATH_ANALOG);           // [R5]
  assign decoded_d.digital_delay_en =
    (path == PATH_BOTH) || (path == PATH_DIGITAL);          // [R5]
  assign decoded_d.status[STS_PSEL_RSVD] = (path == PATH_RSVD);
  assign decoded_d.status[STS_IMP_RSVD]  =
    (ch2_cfg.ch2_input_impedance == IMP_RSVD);              // [R8]
  assign decoded_d.status[STS_CM_RSVD]   =
    (ch2_cfg.ch2_common_mode_tolerance == CM_RSVD);         // [R9]
  // high range needs rail-to-rail and audio band
  assign decoded_d.status[STS_FS_MISUSE] = ch2_cfg.ch2_fullscale_select &&
    ((ch2_cfg.ch2_common_mode_tolerance != CM_RAIL) ||
     ch2_cfg.ch2_bandwidth_select);                         // [R10]
  // wide band needs the 40 k input
  assign decoded_d.status[STS_BW_MISUSE] = ch2_cfg.ch2_bandwidth_select &&
    (ch2_cfg.ch2_input_impedance != IMP_40K);               // [R11]
  // output register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) decoded_q <= DECODED_RST;
    else          decoded_q <= decoded_d;
  end
endmodule : cfg_field_decode
`default_nettype wire

/* design/cfg_reg8.sv */
// one 8-bit config register with a writable-bit mask
`default_nettype none
`timescale 1ns/1ps
module cfg_reg8 #(
  parameter logic [7:0] RST   = 8'h00,  // value after reset
  parameter logic [7:0] WMASK = 8'hff   // bits software may change
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // stored value
  output logic      [7:0] q
);
  logic [7:0] q_d;  // next value
  // masked bits keep their reset value, so reserved bits read zero
  assign q_d = wr_en ? ((wr_data & WMASK) | (q & ~WMASK)) : q;
  // storage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) q <= RST;
    else          q <= q_d;
  end
endmodule : cfg_reg8
`default_nettype wire

/* pkg/adc_cfg_pkg.sv */
// package: map, fields, resets and types of the channel config bank
`default_nettype none
package adc_cfg_pkg;
  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;        // byte address width
  localparam int DATA_W = 32;        // bus data width
  localparam int NREG   = 3;         // number of config registers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] FINE_GAIN_IDX  = 8'h53;
  localparam logic [7:0] PHASE_CAL_IDX  = 8'h54;
  localparam logic [7:0] INPUT_CFG_IDX  = 8'h55;
  localparam logic [7:0] CFG_STATUS_IDX = 8'h60;  // read-only status
  localparam logic [NREG-1:0][7:0] REG_IDX =
    {INPUT_CFG_IDX, PHASE_CAL_IDX, FINE_GAIN_IDX};
  // ---------------------------------------------------------------
  // reset values and writable-bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] FINE_GAIN_RST = 8'h80;
  localparam logic [7:0] PHASE_CAL_RST = 8'h00;
  localparam logic [7:0] INPUT_CFG_RST = 8'h00;
  localparam logic [NREG-1:0][7:0] REG_RST =
    {INPUT_CFG_RST, PHASE_CAL_RST, FINE_GAIN_RST};
  localparam logic [NREG-1:0][7:0] REG_WMASK = {8'hff, 8'hff, 8'hf0};
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FGAIN_LSB  = 4;
  localparam int PDLY_LSB   = 2;
  localparam int PSEL_LSB   = 0;
  localparam int INSRC_LSB  = 6;
  localparam int IMP_LSB    = 4;
  localparam int CMTOL_LSB  = 2;
  localparam int FS_BIT     = 1;
  localparam int BW_BIT     = 0;
  localparam logic [4:0] FGAIN_ZERO_CODE = 5'h08;  // code giving 0 dB
  // status bit positions
  localparam int STS_PSEL_RSVD = 0;
  localparam int STS_IMP_RSVD  = 1;
  localparam int STS_CM_RSVD   = 2;
  localparam int STS_FS_MISUSE = 3;
  localparam int STS_BW_MISUSE = 4;
  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PATH_BOTH, PATH_ANALOG, PATH_DIGITAL,
                            PATH_RSVD} phase_path_t;
  typedef enum logic [1:0] {SRC_DIFF, SRC_SINGLE, SRC_MUX_POS,
                            SRC_MUX_NEG} input_source_t;
  typedef enum logic [1:0] {IMP_5K, IMP_10K, IMP_40K,
                            IMP_RSVD} impedance_t;
  typedef enum logic [1:0] {CM_SMALL, CM_MEDIUM, CM_RAIL,
                            CM_RSVD} cm_tol_t;
  typedef struct packed {
    logic [3:0]  ch1_fine_gain_code;
    logic [5:0]  ch1_phase_delay_cycles;
    phase_path_t phase_path;
  } ch1_cfg_t;
  typedef struct packed {
    input_source_t ch2_input_source;
    impedance_t    ch2_input_impedance;
    cm_tol_t       ch2_common_mode_tolerance;
    logic          ch2_fullscale_select;
    logic          ch2_bandwidth_select;
  } ch2_cfg_t;
  typedef struct packed {
    logic [4:0] fine_gain_tenths_db;  // two's complement, 0.1 dB units
    logic       analog_delay_en;
    logic       digital_delay_en;
    logic [4:0] status;               // reserved-code and misuse flags
  } cfg_decoded_t;
  localparam cfg_decoded_t DECODED_RST = '{5'h00, 1'b1, 1'b1, 5'h00};
  // ---------------------------------------------------------------
  // address decode, used by both write and read paths
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
    addr_hit = (a[ADDR_W-1:2] == {2'h0, idx});
  endfunction : addr_hit
endpackage : adc_cfg_pkg
`default_nettype wire

/* tb/adc_channel_config_regs_tb.sv */
// testbench: config bank over axi4-lite, random and corner cases
`default_nettype none
`timescale 1ns/1ps
module adc_channel_config_regs_tb;
  import adc_cfg_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic              clk, reset_n;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, v;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  ch1_cfg_t          c1;
  ch2_cfg_t          c2;
  cfg_decoded_t      dec;
  logic [7:0]        mdl [NREG];  // expected register contents
  int                err_total, samples_checked;
  adc_channel_config_regs DUT (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ch1_cfg(c1), .ch2_cfg(c2), .cfg_decoded(dec));
  // ---------------------------------------------------------------
  // expectation and comparison helpers
  // ---------------------------------------------------------------
  // expected ports {ch1_cfg, ch2_cfg, cfg_decoded} from the model
  function automatic logic [31:0] cur();
    ch1_cfg_t     a;
    ch2_cfg_t     b;
    cfg_decoded_t d;
    a = {mdl[0][7:4], mdl[1]};
    b = mdl[2];
    d.fine_gain_tenths_db = {1'b0, a.ch1_fine_gain_code} - 5'h08;
    d.analog_delay_en  = a.phase_path inside {PATH_BOTH, PATH_ANALOG};
    d.digital_delay_en = a.phase_path inside {PATH_BOTH, PATH_DIGITAL};
    d.status = {b.ch2_bandwidth_select &&
                b.ch2_input_impedance != IMP_40K,
                b.ch2_fullscale_select &&
                !(b.ch2_common_mode_tolerance == CM_RAIL &&
                  !b.ch2_bandwidth_select),
                b.ch2_common_mode_tolerance == CM_RSVD,
                b.ch2_input_impedance == IMP_RSVD,
                a.phase_path == PATH_RSVD};
    return {a, b, d};
  endfunction : cur
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: response %h want %h", $time, g, e);
    end
  endtask : chk_r
  // settled outputs, sampled mid-cycle
  task automatic chk_outs();
    @(negedge clk);
    chk({c1, c2, dec}, cur(), "config outputs");
  endtask : chk_outs
  // ---------------------------------------------------------------
  // bus master tasks; handshakes judged mid-cycle, acted on at edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) chk_r(bresp, er);
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // fine gain low nibble is read-only
    for (int i = 0; i < NREG; i++)
      if (idx == REG_IDX[i] && s[0]) mdl[i] = d[7:0] & (i ? 8'hff : 8'hf0);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                    input logic [1:0] er);
    logic ta, tr;
    @(posedge clk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr) chk(rdata, {24'h0, e}, "read data");
      if (tr) chk_r(rresp, er);
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd
  // write, look at the config outputs, then read back
  task automatic wrc(input logic [7:0] idx, input logic [31:0] d);
    wr(idx, d, 4'hf, RESP_OKAY);
    chk_outs();
    for (int i = 0; i < NREG; i++)
      if (idx == REG_IDX[i]) rd(idx, mdl[i], RESP_OKAY);
  endtask : wrc
  task automatic t_reset();
    mdl = '{8'h80, 8'h00, 8'h00};
    chk_outs();
    for (int i = 0; i < NREG; i++)
      rd(REG_IDX[i], mdl[i], RESP_OKAY);
    $display("reset values test done");
  endtask : t_reset
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // far above the few hundred cycles the tests need
  initial begin
    #500000;
    err_total++;
    close_out();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    err_total = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    v = $urandom(94);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    // every fine gain code, junk in the unused upper bus bits,
    // reserved low nibble always written as zero
    for (int c = 0; c < 16; c++)
      wrc(FINE_GAIN_IDX, {24'($urandom), c[3:0], 4'h0});
    $display("fine gain test done");
    // delay limits and every path code
    for (int i = 0; i < 12; i++)
      wrc(PHASE_CAL_IDX, {24'h0, i == 0 ? 6'h00 : i == 1 ? 6'h3f
                          : 6'($urandom), i[1:0]});
    $display("phase test done");
    // every code of each channel 2 field, legal combinations only
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      if (i < 4) v[7:2] = {3{i[1:0]}};
      if (v[5:4] != 2'h2) v[0] = 1'b0;
      if (v[3:2] != 2'h2 || v[0]) v[1] = 1'b0;
      wrc(INPUT_CFG_IDX, v);
      v = cur();
      rd(CFG_STATUS_IDX, {3'h0, v[4:0]}, RESP_OKAY);
    end
    $display("channel 2 test done");
    // unmapped place, disabled strobe, read-only status
    wr(8'h56, 32'h5a, 4'hf, RESP_SLVERR);
    rd(8'h56, 8'h00, RESP_SLVERR);
    wr(PHASE_CAL_IDX, ~{24'h0, mdl[1]}, 4'h0, RESP_OKAY);
    wr(CFG_STATUS_IDX, 32'hff, 4'hf, RESP_OKAY);
    chk_outs();
    rd(PHASE_CAL_IDX, mdl[1], RESP_OKAY);
    $display("refusal test done");
    // second reset in mid-run brings back the defaults
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    close_out();
  end
endmodule : adc_channel_config_regs_tb
`default_nettype wire
